/* design/lid_pkg.sv */
// Constants, types and field layouts shared by the instruction decoder files.
// Assumes a single 100 MHz clock and APB register access.
package lid_pkg;
   // ==========================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int EXEC_TIME_NS = 1000;
   localparam int EXEC_CYCLES = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] EXEC_LOAD = CNT_W'(EXEC_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

   // ==========================================
   // Register map
   localparam int APB_AW = 8;
   localparam logic [APB_AW-1:0] ADDR_CMD = 8'h00;
   localparam logic [APB_AW-1:0] ADDR_DATA = 8'h04;
   localparam logic [APB_AW-1:0] ADDR_MODE = 8'h08;
   localparam logic [APB_AW-1:0] ADDR_POS = 8'h0c;

   // ==========================================
   // Memories and addresses
   localparam logic [7:0] BLANK_CHAR = 8'h20;
   localparam logic [6:0] AC_RESET = 7'h00;
   localparam logic [6:0] AC_ONE = 7'h01;
   localparam logic [6:0] FILL_LAST = 7'h7f;
   localparam int DD_DEPTH = 80;
   localparam int CG_DEPTH = 64;
   localparam int ICON_DEPTH = 16;
   localparam int LINE2_LEN = 40;
   localparam int LINE4_LEN = 20;
   localparam int CG_AW = 6;
   localparam int ICON_AW = 4;
   localparam int LINE_EN_W = 4;
   localparam int SQ_W = 6;
   localparam logic [SQ_W-1:0] SQ_MAX = 6'h30;
   localparam logic [1:0] SQ_SAT = 2'h3;

   // ==========================================
   // Instruction groups by highest set data bit
   localparam logic [3:0] TOP_CLEAR = 4'h1;
   localparam logic [3:0] TOP_HOME = 4'h2;
   localparam logic [3:0] TOP_ENTRY = 4'h3;
   localparam logic [3:0] TOP_DISP = 4'h4;
   localparam logic [3:0] TOP_SHIFT = 4'h5;
   localparam logic [3:0] TOP_FUNC = 4'h6;
   localparam logic [3:0] TOP_CGADR = 4'h7;
   localparam logic [3:0] TOP_DDADR = 4'h8;

   // Bit positions inside instruction bytes
   localparam int FS_DL = 4;
   localparam int FS_N = 3;
   localparam int FS_RE = 2;
   localparam int FS_DH = 1;
   localparam int FS_REV = 0;
   localparam int FS_BE = 1;
   localparam int FS_LP = 0;
   localparam int DC_D = 2;
   localparam int DC_C = 1;
   localparam int DC_B = 0;
   localparam int EF_FW = 2;
   localparam int EF_BW = 1;
   localparam int EF_NW = 0;
   localparam int EM_ID = 1;
   localparam int EM_S = 0;
   localparam int EM_BID = 0;
   localparam int SH_SC = 3;
   localparam int SH_RL = 2;

   // ==========================================
   // Types
   typedef enum logic [1:0] {SEL_DD, SEL_CG, SEL_ICON} lid_ramsel_e;
   typedef enum {ST_CLEAR, ST_EXEC, ST_IDLE} lid_state_e;

   typedef struct packed {
      lid_ramsel_e ramSel;
      logic [LINE_EN_W-1:0] scrollLineEn;
      logic [LINE_EN_W-1:0] shiftLineEn;
      logic fourLine;
      logic cursorInvert;
      logic fontWide;
      logic segReverse;
      logic lowPower;
      logic blinkEnable;
      logic reverseDisplayFlag;
      logic horizontalScrollSelect;
      logic extensionRegisterSelect;
      logic twoLine;
      logic eightBit;
      logic entireShift;
      logic increment;
      logic blinkOn;
      logic cursorOn;
      logic displayOn;
   } lid_mode_s;

   typedef struct packed {
      logic [SQ_W-1:0] scrollQty;
      logic [6:0] displayShift;
   } lid_pos_s;

   localparam lid_mode_s MODE_RESET = '{ramSel: SEL_DD, eightBit: 1'b1, twoLine: 1'b1,
      increment: 1'b1, default: '0};
   localparam lid_pos_s POS_RESET = '{default: '0};

   // Index plus one of the highest set bit, zero when no bit is set
   function automatic logic [3:0] lid_top_bit(input logic [7:0] v);
      logic [3:0] pos;
      pos = 4'h0;
      for (int i = 0; i < $bits(v); i++) begin
         if (v[i]) begin
            pos = 4'(i + 1);
         end
      end
      return pos;
   endfunction : lid_top_bit
endpackage : lid_pkg

/* design/lid_if.sv */
// Carriers between the decoder core, its APB slave and its RAM block.
// Assumes lid_pkg is compiled first.
`timescale 1ns/1ns
interface lid_ram_if;
   logic wrEn;
   lid_pkg::lid_ramsel_e sel;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic fourLine;
   modport ctrl(output wrEn, sel, addr, wdata, fourLine, input rdata);
   modport mem(input wrEn, sel, addr, wdata, fourLine, output rdata);
endinterface : lid_ram_if

interface lid_req_if;
   logic wr;
   logic isWrite;
   logic [lid_pkg::APB_AW-1:0] addr;
   logic [7:0] wdata;
   logic [31:0] rdata;
   logic err;
   modport bus(output wr, isWrite, addr, wdata, input rdata, err);
   modport core(input wr, isWrite, addr, wdata, output rdata, err);
endinterface : lid_req_if

/* design/lid_ram.sv */
// Display, character-generator and icon RAM held in flip-flops.
// Assumes writes arrive as single-cycle strobes from the decoder core.
`timescale 1ns/1ns
module lid_ram
   import lid_pkg::*;
(
   input wire logic clk,
   lid_ram_if.mem ram
);
   logic [7:0] dd [DD_DEPTH];
   logic [7:0] cg [CG_DEPTH];
   logic [7:0] icon [ICON_DEPTH];

   // ==========================================
   // Display address to storage index
   wire [6:0] idx4 = 7'(ram.addr[6:5]) * 7'(LINE4_LEN) + 7'(ram.addr[4:0]);
   wire [6:0] idx2 = 7'(ram.addr[6]) * 7'(LINE2_LEN) + 7'(ram.addr[5:0]);
   wire [6:0] ddIdx = ram.fourLine ? idx4 : idx2;
   wire ddValid = ram.fourLine ? (7'(ram.addr[4:0]) < 7'(LINE4_LEN)) : (7'(ram.addr[5:0]) < 7'(LINE2_LEN));
   wire [CG_AW-1:0] cgIdx = ram.addr[CG_AW-1:0];
   wire [ICON_AW-1:0] iconIdx = ram.addr[ICON_AW-1:0];

   // ==========================================
   // Storage
   always_ff @(posedge clk) begin
      if (ram.wrEn) begin
         case (ram.sel)
            SEL_DD: begin
               if (ddValid) begin
                  dd[ddIdx] <= ram.wdata;
               end
            end
            SEL_CG: cg[cgIdx] <= ram.wdata;
            SEL_ICON: icon[iconIdx] <= ram.wdata;
            default: ;
         endcase
      end
   end

   assign ram.rdata = (ram.sel == SEL_CG) ? cg[cgIdx] :
                      (ram.sel == SEL_ICON) ? icon[iconIdx] :
                      ddValid ? dd[ddIdx] : BLANK_CHAR;
endmodule : lid_ram

/* design/lid_apb.sv */
// APB slave front end: one wait state, registered answer.
// Assumes the core answers read data and error combinationally from the address.
`timescale 1ns/1ns
module lid_apb
   import lid_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   lid_req_if.bus req
);
   wire pending = psel & penable & ~pready;

   // ==========================================
   // Answer registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= pending;
         if (pending) begin
            prdata <= pwrite ? 32'h00000000 : req.rdata;
            pslverr <= req.err;
         end
      end
   end

   // Write acts on the completing edge only
   assign req.wr = psel & penable & pready & pwrite & ~pslverr;
   assign req.isWrite = pwrite;
   assign req.addr = paddr;
   assign req.wdata = pwdata[7:0];
endmodule : lid_apb

/* design/lid_decoder.sv */
// Instruction decoder of a character display controller, APB register access.
// Assumes one 100 MHz clock; nrst serves both as power-on and hardware reset.
`timescale 1ns/1ns
module lid_decoder
   import lid_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   lid_req_if reqIf();
   lid_ram_if ramIf();

   lid_state_e state;
   lid_state_e next_state;
   logic [CNT_W-1:0] execCnt;
   logic [CNT_W-1:0] next_execCnt;
   logic [6:0] fillIdx;
   logic [6:0] next_fillIdx;
   logic [6:0] addressCounter;
   logic [6:0] next_addressCounter;
   lid_mode_s mode;
   lid_mode_s next_mode;
   lid_pos_s pos;
   lid_pos_s next_pos;

   // ==========================================
   // Bus slave and RAM
   lid_apb apb (
      .clk(clk),
      .nrst(nrst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .req(reqIf.bus)
   );

   lid_ram ram (
      .clk(clk),
      .ram(ramIf.mem)
   );

   // ==========================================
   // Request decode
   wire [7:0] wd = reqIf.wdata;
   wire busyFlag = (state != ST_IDLE);
   wire addrIsCmd = (reqIf.addr == ADDR_CMD);
   wire addrIsData = (reqIf.addr == ADDR_DATA);
   wire addrIsMode = (reqIf.addr == ADDR_MODE);
   wire addrIsPos = (reqIf.addr == ADDR_POS);
   wire mapped = addrIsCmd | addrIsData | addrIsMode | addrIsPos;
   wire accept = reqIf.wr & ~busyFlag;
   wire cmdWr = accept & addrIsCmd;
   wire dataWr = accept & addrIsData;
   wire [3:0] topBit = lid_top_bit(wd);
   wire extSel = mode.extensionRegisterSelect;
   wire clearing = (state == ST_CLEAR);
   wire [6:0] acUp = addressCounter + AC_ONE;
   wire [6:0] acDown = addressCounter - AC_ONE;
   wire [6:0] acStep = mode.increment ? acUp : acDown;
   wire [6:0] shiftRight = pos.displayShift + AC_ONE;
   wire [6:0] shiftLeft = pos.displayShift - AC_ONE;
   wire [SQ_W-1:0] sqIn = (wd[SQ_W-1:SQ_W-2] == SQ_SAT) ? SQ_MAX : wd[SQ_W-1:0];

   // Busy flag beside the counter; writes while busy are refused
   assign reqIf.rdata = addrIsCmd ? {24'h000000, busyFlag, addressCounter} :
                        addrIsData ? {24'h000000, ramIf.rdata} :
                        addrIsMode ? 32'(mode) :
                        addrIsPos ? 32'(pos) : 32'h00000000;
   assign reqIf.err = ~mapped | (reqIf.isWrite & (addrIsMode | addrIsPos | busyFlag));

   // ==========================================
   // RAM port: blanking fill or host data
   assign ramIf.wrEn = clearing | dataWr;
   assign ramIf.sel = clearing ? SEL_DD : mode.ramSel;
   assign ramIf.addr = clearing ? fillIdx : addressCounter;
   assign ramIf.wdata = clearing ? BLANK_CHAR : wd;
   assign ramIf.fourLine = mode.fourLine;

   // ==========================================
   // Instruction execution
   always_comb begin
      next_state = state;
      next_execCnt = execCnt;
      next_fillIdx = fillIdx;
      next_addressCounter = addressCounter;
      next_mode = mode;
      next_pos = pos;
      case (state)
         ST_CLEAR: begin
            next_fillIdx = fillIdx + AC_ONE;
            if (fillIdx == FILL_LAST) begin
               next_state = ST_IDLE;
            end
         end
         ST_EXEC: begin
            if (execCnt == CNT_ZERO) begin
               next_state = ST_IDLE;
            end else begin
               next_execCnt = execCnt - CNT_W'(1);
            end
         end
         ST_IDLE: begin
            if (dataWr) begin
               next_addressCounter = acStep;
               if (mode.entireShift && mode.ramSel == SEL_DD) begin
                  next_pos.displayShift = mode.increment ? shiftLeft : shiftRight;
               end
               next_state = ST_EXEC;
               next_execCnt = EXEC_LOAD;
            end else if (cmdWr) begin
               next_state = ST_EXEC;
               next_execCnt = EXEC_LOAD;
               case (topBit)
                  TOP_CLEAR: begin
                     next_addressCounter = AC_RESET;
                     next_pos.displayShift = POS_RESET.displayShift;
                     next_mode.ramSel = SEL_DD;
                     next_state = ST_CLEAR;
                     next_fillIdx = AC_RESET;
                  end
                  TOP_HOME: begin
                     next_addressCounter = AC_RESET;
                     next_pos.displayShift = POS_RESET.displayShift;
                     next_mode.ramSel = SEL_DD;
                  end
                  TOP_ENTRY: begin
                     if (extSel) begin
                        next_mode.segReverse = wd[EM_BID];
                     end else begin
                        next_mode.increment = wd[EM_ID];
                        next_mode.entireShift = wd[EM_S];
                     end
                  end
                  TOP_DISP: begin
                     if (extSel) begin
                        next_mode.fontWide = wd[EF_FW];
                        next_mode.cursorInvert = wd[EF_BW];
                        next_mode.fourLine = wd[EF_NW];
                     end else begin
                        next_mode.displayOn = wd[DC_D];
                        next_mode.cursorOn = wd[DC_C];
                        next_mode.blinkOn = wd[DC_B];
                     end
                  end
                  TOP_SHIFT: begin
                     if (extSel) begin
                        if (mode.horizontalScrollSelect) begin
                           next_mode.scrollLineEn = wd[LINE_EN_W-1:0];
                        end else begin
                           next_mode.shiftLineEn = wd[LINE_EN_W-1:0];
                        end
                     end else if (wd[SH_SC]) begin
                        next_pos.displayShift = wd[SH_RL] ? shiftRight : shiftLeft;
                     end else begin
                        next_addressCounter = wd[SH_RL] ? acUp : acDown;
                     end
                  end
                  TOP_FUNC: begin
                     next_mode.eightBit = wd[FS_DL];
                     next_mode.twoLine = wd[FS_N];
                     next_mode.extensionRegisterSelect = wd[FS_RE];
                     if (extSel) begin
                        next_mode.blinkEnable = wd[FS_BE];
                        next_mode.lowPower = wd[FS_LP];
                     end else begin
                        next_mode.horizontalScrollSelect = wd[FS_DH];
                        next_mode.reverseDisplayFlag = wd[FS_REV];
                     end
                  end
                  TOP_CGADR: begin
                     if (extSel) begin
                        next_addressCounter = 7'(wd[ICON_AW-1:0]);
                        next_mode.ramSel = SEL_ICON;
                     end else begin
                        next_addressCounter = 7'(wd[CG_AW-1:0]);
                        next_mode.ramSel = SEL_CG;
                     end
                  end
                  TOP_DDADR: begin
                     if (extSel) begin
                        next_pos.scrollQty = sqIn;
                     end else begin
                        next_addressCounter = wd[6:0];
                        next_mode.ramSel = SEL_DD;
                     end
                  end
                  default: ;
               endcase
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // ==========================================
   // State registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= ST_CLEAR;
         execCnt <= CNT_ZERO;
         fillIdx <= AC_RESET;
         addressCounter <= AC_RESET;
         mode <= MODE_RESET;
         pos <= POS_RESET;
      end else begin
         state <= next_state;
         execCnt <= next_execCnt;
         fillIdx <= next_fillIdx;
         addressCounter <= next_addressCounter;
         mode <= next_mode;
         pos <= next_pos;
      end
   end
endmodule : lid_decoder

/* bench/lid_decoder_assertions.sv */
// Checker on the decoder's APB port: handshake, busy and address relations.
// Assumes a bind from the bench top file and the single clk domain.
`timescale 1ns/1ns
module lid_chk
   import lid_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // ==========================================
   // Helper state
   logic [7:0] sinceRst;
   logic [7:0] busyCnt;
   logic [6:0] acExp;
   logic acOk;
   logic extSel;
   wire logic wrOk = pready && pwrite && !pslverr;
   wire logic accCmd = wrOk && paddr == ADDR_CMD;
   wire logic accDat = wrOk && paddr == ADDR_DATA;
   wire logic cmdRd = pready && !pwrite && paddr == ADDR_CMD;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         sinceRst <= 8'h00;
         busyCnt <= 8'h00;
         acOk <= 1'b0;
         extSel <= 1'b0;
         acExp <= 7'h00;
      end else begin
         sinceRst <= (sinceRst == 8'hff) ? sinceRst : sinceRst + 8'h01;
         if (accCmd || accDat) begin
            busyCnt <= (accCmd && pwdata[7:0] == 8'h01) ? 8'h80 : 8'(EXEC_CYCLES);
            acOk <= accCmd && pwdata[7] && !extSel;
            acExp <= pwdata[6:0];
         end else if (busyCnt != 8'h00) begin
            busyCnt <= busyCnt - 8'h01;
         end
         if (accCmd && pwdata[7:5] == 3'b001) begin
            extSel <= pwdata[2];
         end
      end
   end

   // ==========================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   AST_READY_WAIT: assert property (psel && penable && !$past(penable) |=> pready)
      else $error("pready late");
   AST_READY_ONE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_IDLE_QUIET: assert property (!psel |=> !pready)
      else $error("pready without a transfer");
   AST_RESET_BUSY: assert property (cmdRd && sinceRst < 8'd120 |-> prdata[7])
      else $error("not busy during reset fill");
   AST_BUSY_REFUSE: assert property (pready && pwrite && (paddr == ADDR_CMD || paddr == ADDR_DATA)
      && busyCnt > 8'd2 |-> pslverr)
      else $error("write taken while busy");
   AST_BUSY_READ: assert property (cmdRd && busyCnt > 8'd2 |-> prdata[7])
      else $error("busy bit low during execution");
   AST_RO_REFUSE: assert property (pready && pwrite && (paddr == ADDR_MODE || paddr == ADDR_POS)
      |-> pslverr)
      else $error("read-only write accepted");
   AST_AC_LOAD: assert property (cmdRd && acOk && busyCnt == 8'd0 |-> prdata[6:0] == acExp)
      else $error("address counter not loaded");

   CV_CLEAR: cover property (accCmd && pwdata[7:0] == 8'h01);
   CV_DATA: cover property (accDat);
   CV_REFUSE: cover property (pready && pslverr);
endmodule : lid_chk

/* bench/lid_host_model.sv */
// Host model: APB master that issues instructions and polls busy first.
// Assumes the bench pops one note from expV and expM per answer.
`timescale 1ns/1ns
module lid_host_model
   import lid_pkg::*;
(
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [APB_AW-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic [32:0] expV[$];
   logic [32:0] expM[$];
   int gap;

   initial begin
      gap = 0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end

   // ==========================================
   // One transfer, held until pready
   task xfer(input logic wr, input logic [APB_AW-1:0] ad, input logic [31:0] d,
      input logic [32:0] v, input logic [32:0] m, output logic [31:0] rd);
      expV.push_back(v);
      expM.push_back(m);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~paddr;
      pwdata <= ~pwdata;
   endtask : xfer

   task waitIdle();
      logic [31:0] r;
      r = 32'h80;
      while (r[7] !== 1'b0) begin
         xfer(1'b0, ADDR_CMD, 32'h0, 33'h0, {1'b1, 32'h0}, r);
      end
   endtask : waitIdle
endmodule : lid_host_model

/* bench/lid_decoder_tb.sv */
// Bench top: host model drives instructions, monitor compares each answer.
// Assumes lid_pkg, the design files and the checker are compiled first.
`timescale 1ns/1ns
module lid_decoder_tb
   import lid_pkg::*;
();
   logic clk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [APB_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [32:0] mv, mm;
   logic [7:0] b;
   logic [7:0] txt[4];
   logic [6:0] a;
   int errTotal, checks, seed;
   lid_mode_s m;
   lid_pos_s p;

   lid_decoder uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   lid_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========================================
   // Checking
   task check(input logic [32:0] got, input logic [32:0] exp);
      checks++;
      if (got !== exp) begin
         errTotal++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   always @(posedge clk) begin
      if (pready === 1'b1 && host.expM.size() > 0) begin
         mv = host.expV.pop_front();
         mm = host.expM.pop_front();
         if (mm != 33'h0) begin
            check({pslverr, prdata} & mm, mv & mm);
         end
      end
   end

   task giveVerdict();
      $display("checks=%0d mismatches=%0d", checks, errTotal);
      if (errTotal == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : giveVerdict

   initial begin
      repeat (30000) @(posedge clk);
      errTotal++;
      giveVerdict();
   end

   // ==========================================
   // Bus helpers
   task tx(input logic wr, input logic [7:0] ad, input logic [31:0] d, input logic [32:0] e);
      host.xfer(wr, ad, d, e, {33{1'b1}}, rdv);
   endtask : tx
   task cmd(input logic [7:0] c);
      host.waitIdle();
      tx(1'b1, ADDR_CMD, {24'h0, c}, 33'h0);
   endtask : cmd
   task dat(input logic [7:0] c);
      host.waitIdle();
      tx(1'b1, ADDR_DATA, {24'h0, c}, 33'h0);
   endtask : dat
   task rd(input logic [7:0] ad, input logic [31:0] v);
      host.waitIdle();
      tx(1'b0, ad, 32'h0, {1'b0, v});
   endtask : rd

   // ==========================================
   // Scenarios
   initial begin
      seed = 32'h1a90;
      errTotal = 0;
      checks = 0;
      nrst = 1'b0;
      m = MODE_RESET;
      p = POS_RESET;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      host.xfer(1'b0, ADDR_CMD, 32'h0, {1'b0, 32'h80}, {1'b1, 32'h80}, rdv);
      tx(1'b1, ADDR_CMD, 32'h38, {1'b1, 32'h0});
      rd(ADDR_MODE, 32'(m));
      tx(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
      tx(1'b1, ADDR_POS, 32'h1, {1'b1, 32'h0});
      $display("reset test done");
      cmd(8'h30);
      m.twoLine = 1'b0;
      rd(ADDR_MODE, 32'(m));
      host.gap = 1;
      for (int i = 0; i < 4; i++) begin
         b = 8'h30 | 8'($random(seed)) & 8'h08 | 8'(i);
         cmd(b);
         m.twoLine = b[3];
         m.horizontalScrollSelect = b[1];
         m.reverseDisplayFlag = b[0];
         rd(ADDR_MODE, 32'(m));
      end
      host.gap = 0;
      $display("function set test done");
      cmd(8'h0e);
      tx(1'b1, ADDR_CMD, 32'h04, {1'b1, 32'h0});
      m.displayOn = 1'b1;
      m.cursorOn = 1'b1;
      rd(ADDR_MODE, 32'(m));
      cmd(8'h05);
      m.increment = 1'b0;
      m.entireShift = 1'b1;
      rd(ADDR_MODE, 32'(m));
      cmd(8'h06);
      m.increment = 1'b1;
      m.entireShift = 1'b0;
      rd(ADDR_MODE, 32'(m));
      $display("control test done");
      cmd(8'h38);
      m.twoLine = 1'b1;
      m.horizontalScrollSelect = 1'b0;
      m.reverseDisplayFlag = 1'b0;
      rd(ADDR_MODE, 32'(m));
      a = 7'h60 + 7'($random(seed) & 3);
      cmd({1'b1, a});
      rd(ADDR_CMD, {25'h0, a});
      for (int k = 0; k < 4; k++) begin
         txt[k] = 8'($random(seed));
         dat(txt[k]);
         rd(ADDR_CMD, {25'h0, a + 7'(k + 1)});
      end
      for (int k = 0; k < 4; k++) begin
         cmd({1'b1, a + 7'(k)});
         rd(ADDR_DATA, {24'h0, txt[k]});
      end
      cmd(8'h04);
      dat(txt[0]);
      rd(ADDR_CMD, {25'h0, a + 7'd2});
      cmd(8'h06);
      $display("data test done");
      cmd(8'h1c);
      p.displayShift = 7'h01;
      rd(ADDR_POS, 32'(p));
      cmd({1'b1, a});
      rd(ADDR_DATA, {24'h0, txt[0]});
      cmd(8'h3c);
      m.extensionRegisterSelect = 1'b1;
      rd(ADDR_MODE, 32'(m));
      cmd(8'h83);
      p.scrollQty = 6'h03;
      rd(ADDR_POS, 32'(p));
      rd(ADDR_CMD, {25'h0, a});
      cmd(8'h38);
      m.extensionRegisterSelect = 1'b0;
      rd(ADDR_MODE, 32'(m));
      $display("shift test done");
      cmd(8'h01);
      rd(ADDR_CMD, 32'h0);
      p.displayShift = 7'h00;
      rd(ADDR_POS, 32'(p));
      cmd({1'b1, a});
      rd(ADDR_DATA, {24'h0, BLANK_CHAR});
      cmd(8'h45);
      m.ramSel = SEL_CG;
      dat(txt[1]);
      rd(ADDR_CMD, 32'h06);
      cmd(8'h45);
      rd(ADDR_DATA, {24'h0, txt[1]});
      rd(ADDR_MODE, 32'(m));
      cmd(8'h3e);
      cmd(8'h15);
      cmd(8'h09);
      m.extensionRegisterSelect = 1'b1;
      m.horizontalScrollSelect = 1'b1;
      m.scrollLineEn = 4'h5;
      m.fourLine = 1'b1;
      rd(ADDR_MODE, 32'(m));
      cmd(8'h4a);
      dat(txt[2]);
      rd(ADDR_CMD, 32'h0b);
      cmd(8'h4a);
      rd(ADDR_DATA, {24'h0, txt[2]});
      cmd(8'h38);
      cmd(8'he0);
      dat(txt[3]);
      cmd(8'he0);
      rd(ADDR_DATA, {24'h0, txt[3]});
      cmd(8'h02);
      m.extensionRegisterSelect = 1'b0;
      m.ramSel = SEL_DD;
      rd(ADDR_CMD, 32'h0);
      rd(ADDR_MODE, 32'(m));
      $display("extension test done");
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      m = MODE_RESET;
      rd(ADDR_MODE, 32'(m));
      $display("clear and reset test done");
      giveVerdict();
   end
endmodule : lid_decoder_tb

bind lid_decoder lid_chk chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
